//--- rtl/reader_upper_regs.v
// upper register bank, io configuration register and clock output selection
`timescale 1ns/1ns
`include "reader_regs_map.vh"

module reader_upper_regs #(
    parameter IDENTITY_CODE = 8'h5a, // arbitrary neutral value
    parameter LF_DIV_HALF   = 16'd390 // 25 MHz / 32 kHz / 2
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       set_default,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire [5:0] addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    output wire       addr_hit,
    input  wire       xtal_clk,
    input  wire       xtal_running,
    input  wire [7:0] ant_cal_in,
    input  wire [7:0] mod_depth_in,
    input  wire [7:0] reg_timer_in,
    input  wire [7:0] sig_strength_in,
    input  wire [7:0] gain_red_in,
    input  wire [7:0] cap_sensor_in,
    input  wire [7:0] aux_in,
    input  wire [7:0] amp_avg_in,
    input  wire [7:0] amp_res_in,
    input  wire [7:0] ph_avg_in,
    input  wire [7:0] ph_res_in,
    input  wire [7:0] capm_avg_in,
    input  wire [7:0] capm_res_in,
    output reg        driver_a_en,
    output reg        driver_b_en,
    output reg        differential,
    output reg  [6:0] rx_water_level,
    output reg  [6:0] tx_water_level,
    output reg        xtal_27m,
    output reg        mcu_clk,
    output reg  [7:0] antenna_cal_control,
    output reg  [7:0] antenna_cal_target,
    output reg  [7:0] mod_depth_control,
    output reg  [7:0] driver_modulated_level,
    output reg  [7:0] driver_normal_level,
    output reg  [7:0] field_detect_threshold,
    output reg  [7:0] regulator_voltage_control,
    output reg  [7:0] cap_sensor_control,
    output reg  [7:0] wake_timer_control,
    output reg  [7:0] amplitude_meas_config,
    output reg  [7:0] amplitude_meas_reference,
    output reg  [7:0] phase_meas_config,
    output reg  [7:0] phase_meas_reference,
    output reg  [7:0] capacitance_meas_config,
    output reg  [7:0] capacitance_meas_reference
);

////////////////////////////////////////////////////////////////////////////
reg  [7:0] io_drive_clock_config;
reg  [7:0] next_rd_data;
reg        next_hit;
reg  [7:0] ro_sync1 [0:12];
reg  [7:0] ro_sync2 [0:12];
reg  [7:0] ro_sync3 [0:12];
reg  [7:0] ro_word  [0:12];
reg        run_s1;
reg        run_s2;
reg        xtal_s1;
reg        xtal_s2;
reg        xtal_d;
reg  [3:0] div_cnt;
reg  [15:0] lf_cnt;
reg        lf_clk;
reg        hf_clk;
integer    i;
wire [7:0] ro_in [0:12];
wire [1:0] clk_sel;
wire [3:0] div_ratio;

assign ro_in[0]  = ant_cal_in;
assign ro_in[1]  = mod_depth_in;
assign ro_in[2]  = reg_timer_in;
assign ro_in[3]  = sig_strength_in;
assign ro_in[4]  = gain_red_in;
assign ro_in[5]  = cap_sensor_in;
assign ro_in[6]  = aux_in;
assign ro_in[7]  = amp_avg_in;
assign ro_in[8]  = amp_res_in;
assign ro_in[9]  = ph_avg_in;
assign ro_in[10] = ph_res_in;
assign ro_in[11] = capm_avg_in;
assign ro_in[12] = capm_res_in;
assign addr_hit  = next_hit;

function is_addr;
    input [5:0] a;
    input [5:0] b;
    begin
        is_addr = (a == b);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// display inputs come from analog blocks on other timing
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        for (i = 0; i < 13; i = i + 1) begin
            ro_sync1[i] <= 8'h00;
            ro_sync2[i] <= 8'h00;
            ro_sync3[i] <= 8'h00;
            ro_word[i]  <= 8'h00;
        end
        run_s1  <= 1'b0;
        run_s2  <= 1'b0;
        xtal_s1 <= 1'b0;
        xtal_s2 <= 1'b0;
    end else begin
        for (i = 0; i < 13; i = i + 1) begin
            ro_sync1[i] <= ro_in[i];
            ro_sync2[i] <= ro_sync1[i];
            ro_sync3[i] <= ro_sync2[i];
            // bits may skew across the sync; take a word only once it
            // stood alike on two edges, so a read never shows it torn
            if (ro_sync2[i] == ro_sync3[i]) begin
                ro_word[i] <= ro_sync3[i];
            end
        end
        run_s1  <= xtal_running;
        run_s2  <= run_s1;
        xtal_s1 <= xtal_clk;
        xtal_s2 <= xtal_s1;
    end
end

////////////////////////////////////////////////////////////////////////////
// io configuration defaults only on power-up reset
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        io_drive_clock_config <= `IO_CFG_RESET;
    end else if (wr_en && is_addr(addr, `ADDR_IO_CFG)) begin
        io_drive_clock_config <= wr_data;
    end
end

// set-default clears the rest; writable entries
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        antenna_cal_control        <= `CFG_RESET;
        antenna_cal_target         <= `CFG_RESET;
        mod_depth_control          <= `CFG_RESET;
        driver_modulated_level     <= `CFG_RESET;
        driver_normal_level        <= `CFG_RESET;
        field_detect_threshold     <= `CFG_RESET;
        regulator_voltage_control  <= `CFG_RESET;
        cap_sensor_control         <= `CFG_RESET;
        wake_timer_control         <= `CFG_RESET;
        amplitude_meas_config      <= `CFG_RESET;
        amplitude_meas_reference   <= `CFG_RESET;
        phase_meas_config          <= `CFG_RESET;
        phase_meas_reference       <= `CFG_RESET;
        capacitance_meas_config    <= `CFG_RESET;
        capacitance_meas_reference <= `CFG_RESET;
    end else if (set_default) begin
        antenna_cal_control        <= `CFG_RESET;
        antenna_cal_target         <= `CFG_RESET;
        mod_depth_control          <= `CFG_RESET;
        driver_modulated_level     <= `CFG_RESET;
        driver_normal_level        <= `CFG_RESET;
        field_detect_threshold     <= `CFG_RESET;
        regulator_voltage_control  <= `CFG_RESET;
        cap_sensor_control         <= `CFG_RESET;
        wake_timer_control         <= `CFG_RESET;
        amplitude_meas_config      <= `CFG_RESET;
        amplitude_meas_reference   <= `CFG_RESET;
        phase_meas_config          <= `CFG_RESET;
        phase_meas_reference       <= `CFG_RESET;
        capacitance_meas_config    <= `CFG_RESET;
        capacitance_meas_reference <= `CFG_RESET;
    end else if (wr_en) begin
        if (is_addr(addr, `ADDR_ANT_CTRL)) begin
            antenna_cal_control <= wr_data;
        end else if (is_addr(addr, `ADDR_ANT_TARGET)) begin
            antenna_cal_target <= wr_data;
        end else if (is_addr(addr, `ADDR_MOD_CTRL)) begin
            mod_depth_control <= wr_data;
        end else if (is_addr(addr, `ADDR_DRV_MOD_LVL)) begin
            driver_modulated_level <= wr_data;
        end else if (is_addr(addr, `ADDR_DRV_NORM_LVL)) begin
            driver_normal_level <= wr_data;
        end else if (is_addr(addr, `ADDR_FIELD_THR)) begin
            field_detect_threshold <= wr_data;
        end else if (is_addr(addr, `ADDR_REG_VCTRL)) begin
            regulator_voltage_control <= wr_data;
        end else if (is_addr(addr, `ADDR_CAP_CTRL)) begin
            cap_sensor_control <= wr_data;
        end else if (is_addr(addr, `ADDR_WAKE_TMR)) begin
            wake_timer_control <= wr_data;
        end else if (is_addr(addr, `ADDR_AMP_CFG)) begin
            amplitude_meas_config <= wr_data;
        end else if (is_addr(addr, `ADDR_AMP_REF)) begin
            amplitude_meas_reference <= wr_data;
        end else if (is_addr(addr, `ADDR_PH_CFG)) begin
            phase_meas_config <= wr_data;
        end else if (is_addr(addr, `ADDR_PH_REF)) begin
            phase_meas_reference <= wr_data;
        end else if (is_addr(addr, `ADDR_CAPM_CFG)) begin
            capacitance_meas_config <= wr_data;
        end else if (is_addr(addr, `ADDR_CAPM_REF)) begin
            capacitance_meas_reference <= wr_data;
        end
        // displays, 28 and 3e fall through unchanged
    end
end

////////////////////////////////////////////////////////////////////////////
// read decode
always @* begin
    next_hit     = 1'b1;
    next_rd_data = 8'h00;
    if (is_addr(addr, `ADDR_IO_CFG)) begin
        next_rd_data = io_drive_clock_config;
    end else if (is_addr(addr, `ADDR_ANT_CTRL)) begin
        next_rd_data = antenna_cal_control;
    end else if (is_addr(addr, `ADDR_ANT_TARGET)) begin
        next_rd_data = antenna_cal_target;
    end else if (is_addr(addr, `ADDR_ANT_RESULT)) begin
        next_rd_data = ro_word[0];
    end else if (is_addr(addr, `ADDR_MOD_CTRL)) begin
        next_rd_data = mod_depth_control;
    end else if (is_addr(addr, `ADDR_MOD_RESULT)) begin
        next_rd_data = ro_word[1];
    end else if (is_addr(addr, `ADDR_DRV_MOD_LVL)) begin
        next_rd_data = driver_modulated_level;
    end else if (is_addr(addr, `ADDR_DRV_NORM_LVL)) begin
        next_rd_data = driver_normal_level;
    end else if (is_addr(addr, `ADDR_FIELD_THR)) begin
        next_rd_data = field_detect_threshold;
    end else if (is_addr(addr, `ADDR_REG_VCTRL)) begin
        next_rd_data = regulator_voltage_control;
    end else if (is_addr(addr, `ADDR_REG_TMR_STAT)) begin
        next_rd_data = ro_word[2];
    end else if (is_addr(addr, `ADDR_SIG_STRENGTH)) begin
        next_rd_data = ro_word[3];
    end else if (is_addr(addr, `ADDR_GAIN_RED)) begin
        next_rd_data = ro_word[4];
    end else if (is_addr(addr, `ADDR_CAP_CTRL)) begin
        next_rd_data = cap_sensor_control;
    end else if (is_addr(addr, `ADDR_CAP_RESULT)) begin
        next_rd_data = ro_word[5];
    end else if (is_addr(addr, `ADDR_AUX_STAT)) begin
        next_rd_data = ro_word[6];
    end else if (is_addr(addr, `ADDR_WAKE_TMR)) begin
        next_rd_data = wake_timer_control;
    end else if (is_addr(addr, `ADDR_AMP_CFG)) begin
        next_rd_data = amplitude_meas_config;
    end else if (is_addr(addr, `ADDR_AMP_REF)) begin
        next_rd_data = amplitude_meas_reference;
    end else if (is_addr(addr, `ADDR_AMP_AVG)) begin
        next_rd_data = ro_word[7];
    end else if (is_addr(addr, `ADDR_AMP_RES)) begin
        next_rd_data = ro_word[8];
    end else if (is_addr(addr, `ADDR_PH_CFG)) begin
        next_rd_data = phase_meas_config;
    end else if (is_addr(addr, `ADDR_PH_REF)) begin
        next_rd_data = phase_meas_reference;
    end else if (is_addr(addr, `ADDR_PH_AVG)) begin
        next_rd_data = ro_word[9];
    end else if (is_addr(addr, `ADDR_PH_RES)) begin
        next_rd_data = ro_word[10];
    end else if (is_addr(addr, `ADDR_CAPM_CFG)) begin
        next_rd_data = capacitance_meas_config;
    end else if (is_addr(addr, `ADDR_CAPM_REF)) begin
        next_rd_data = capacitance_meas_reference;
    end else if (is_addr(addr, `ADDR_CAPM_AVG)) begin
        next_rd_data = ro_word[11];
    end else if (is_addr(addr, `ADDR_CAPM_RES)) begin
        next_rd_data = ro_word[12];
    end else if (is_addr(addr, `ADDR_IDENTITY)) begin
        next_rd_data = IDENTITY_CODE;
    end else begin
        // lower map lives elsewhere; unassigned reads give zero
        next_hit = 1'b0;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        rd_data  <= 8'h00;
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= rd_en;
        if (rd_en) begin
            rd_data <= next_rd_data;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
assign clk_sel = {io_drive_clock_config[`IO_CLK_HI_BIT],
                  io_drive_clock_config[`IO_CLK_LO_BIT]};
// code 01 is the intermediate divide
assign div_ratio = (clk_sel == `CLK_SEL_6M78)  ? `DIV_6M78_X13 :
                   (clk_sel == `CLK_SEL_13M56) ? `DIV_13M56_X13 :
                   `DIV_3M39_X13;

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        driver_a_en    <= 1'b1;
        driver_b_en    <= 1'b1;
        differential   <= 1'b1;
        rx_water_level <= `RX_LEVEL_LOW;
        tx_water_level <= `TX_LEVEL_LOW;
        xtal_27m       <= 1'b1;
    end else begin
        differential <= ~io_drive_clock_config[`IO_SINGLE_BIT];
        driver_a_en  <= ~io_drive_clock_config[`IO_SINGLE_BIT] |
                        ~io_drive_clock_config[`IO_SECOND_DRV_BIT];
        driver_b_en  <= ~io_drive_clock_config[`IO_SINGLE_BIT] |
                        io_drive_clock_config[`IO_SECOND_DRV_BIT];
        rx_water_level <= io_drive_clock_config[`IO_RX_LEVEL_BIT] ?
                          `RX_LEVEL_HIGH : `RX_LEVEL_LOW;
        tx_water_level <= io_drive_clock_config[`IO_TX_LEVEL_BIT] ?
                          `TX_LEVEL_HIGH : `TX_LEVEL_LOW;
        // crystal select, host gates its fast rates on it
        xtal_27m <= io_drive_clock_config[`IO_XTAL_BIT];
    end
end

// divider counts crystal rising edges; a 27.12 MHz crystal doubles the ratio
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        xtal_d  <= 1'b0;
        div_cnt <= 4'h0;
        hf_clk  <= 1'b0;
        lf_cnt  <= 16'h0000;
        lf_clk  <= 1'b0;
    end else begin
        xtal_d <= xtal_s2;
        if (xtal_s2 & ~xtal_d) begin
            if (div_cnt >= ((xtal_27m ? {div_ratio[2:0], 1'b0} : div_ratio)
                            >> 1) - 4'h1) begin
                div_cnt <= 4'h0;
                hf_clk  <= ~hf_clk;
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
        if (lf_cnt >= LF_DIV_HALF - 16'h0001) begin
            lf_cnt <= 16'h0000;
            lf_clk <= ~lf_clk;
        end else begin
            lf_cnt <= lf_cnt + 16'h0001;
        end
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        mcu_clk <= 1'b0;
    end else if (clk_sel == `CLK_SEL_OFF) begin
        mcu_clk <= 1'b0;
    end else if (run_s2) begin
        mcu_clk <= (div_ratio == `DIV_13M56_X13 && !xtal_27m) ?
                   xtal_s2 : hf_clk;
    end else if (io_drive_clock_config[`IO_LF_OFF_BIT]) begin
        mcu_clk <= 1'b0;
    end else begin
        mcu_clk <= lf_clk;
    end
end

endmodule

//--- rtl/reader_regs_map.vh
// register map, field positions and defaults of the reader register bank
// Functional notes
// - single-drive bit 7 set: one antenna driver only, else differential.
// - in single drive, bit 6 picks driver a (0) or driver b (1).
// - receive water level 64 bytes when clear, 80 bytes when set.
// - transmit water level 32 bytes when clear, 16 bytes when set.
// - crystal select: 0 is 13.56 MHz, 1 is 27.12 MHz; powers up 1.
// - clock field: 00 gives 3.39 MHz, 10 gives 13.56 MHz, 11 off.
// - crystal stopped and output enabled: 32 kHz clock on the pin.
// - low-frequency-clock-off bit 0 set suppresses the 32 kHz clock.
// - io configuration fields default only at power-up.
// - antenna calibration 21-23, modulation depth 24-25, drive levels 26-27, field threshold 29.
// - regulator control 2a read-write; 2b to 2d read-only displays.
// - capacitive sensor control 2e; displays 2f and 30 read-only.
// - wake-up timer 31; measurement config/ref writable, displays read.
// - read-only identity register at 3f.
// - configuration registers read-write, displays read-only over spi.
// - set-default restores all but io configuration registers.
`ifndef READER_REGS_MAP_VH
`define READER_REGS_MAP_VH

`define ADDR_IO_CFG        6'h00
`define ADDR_ANT_CTRL      6'h21
`define ADDR_ANT_TARGET    6'h22
`define ADDR_ANT_RESULT    6'h23
`define ADDR_MOD_CTRL      6'h24
`define ADDR_MOD_RESULT    6'h25
`define ADDR_DRV_MOD_LVL   6'h26
`define ADDR_DRV_NORM_LVL  6'h27
`define ADDR_FIELD_THR     6'h29
`define ADDR_REG_VCTRL     6'h2a
`define ADDR_REG_TMR_STAT  6'h2b
`define ADDR_SIG_STRENGTH  6'h2c
`define ADDR_GAIN_RED      6'h2d
`define ADDR_CAP_CTRL      6'h2e
`define ADDR_CAP_RESULT    6'h2f
`define ADDR_AUX_STAT      6'h30
`define ADDR_WAKE_TMR      6'h31
`define ADDR_AMP_CFG       6'h32
`define ADDR_AMP_REF       6'h33
`define ADDR_AMP_AVG       6'h34
`define ADDR_AMP_RES       6'h35
`define ADDR_PH_CFG        6'h36
`define ADDR_PH_REF        6'h37
`define ADDR_PH_AVG        6'h38
`define ADDR_PH_RES        6'h39
`define ADDR_CAPM_CFG      6'h3a
`define ADDR_CAPM_REF      6'h3b
`define ADDR_CAPM_AVG      6'h3c
`define ADDR_CAPM_RES      6'h3d
`define ADDR_IDENTITY      6'h3f

// io configuration field positions
`define IO_SINGLE_BIT      7
`define IO_SECOND_DRV_BIT  6
`define IO_RX_LEVEL_BIT    5
`define IO_TX_LEVEL_BIT    4
`define IO_XTAL_BIT        3
`define IO_CLK_HI_BIT      2
`define IO_CLK_LO_BIT      1
`define IO_LF_OFF_BIT      0
`define IO_CFG_RESET       8'h08
`define CFG_RESET          8'h00

// water levels in bytes
`define RX_LEVEL_LOW       7'h40
`define RX_LEVEL_HIGH      7'h50
`define TX_LEVEL_LOW       7'h20
`define TX_LEVEL_HIGH      7'h10

// clock output field codes
`define CLK_SEL_3M39       2'h0
`define CLK_SEL_6M78       2'h1
`define CLK_SEL_13M56      2'h2
`define CLK_SEL_OFF        2'h3

// divide ratios from a 13.56 MHz crystal; the divider doubles them for 27.12 MHz
`define DIV_3M39_X13       4'h4
`define DIV_6M78_X13       4'h2
`define DIV_13M56_X13      4'h1

`endif

//--- bench/reader_upper_regs_props.sv
// assertion checker for the upper register bank and io configuration
`timescale 1ns/1ns
module reader_upper_regs_props (
    input wire       clk,
    input wire       sys_rst,
    input wire       set_default,
    input wire       wr_en,
    input wire       rd_en,
    input wire [5:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire       rd_valid,
    input wire       addr_hit,
    input wire       xtal_running,
    input wire       driver_a_en,
    input wire       driver_b_en,
    input wire       differential,
    input wire [6:0] rx_water_level,
    input wire [6:0] tx_water_level,
    input wire       xtal_27m,
    input wire       mcu_clk,
    input wire [7:0] antenna_cal_target
);
    // io register as last written; set-default must leave it alone
    reg [7:0] io_shadow;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            io_shadow <= 8'h08;
        else if (wr_en && addr == 6'h00)
            io_shadow <= wr_data;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence io_settled;
        $stable(io_shadow) [*3];
    endsequence
    a_drive_mode:
        assert property (io_settled |-> differential == !io_shadow[7] &&
            driver_a_en == (!io_shadow[7] || !io_shadow[6]) &&
            driver_b_en == (!io_shadow[7] || io_shadow[6]))
        else $error("antenna driver selection wrong");
    a_rx_level:
        assert property (io_settled |-> rx_water_level ==
            (io_shadow[5] ? 7'h50 : 7'h40)) else $error("rx level wrong");
    a_tx_level:
        assert property (io_settled |-> tx_water_level ==
            (io_shadow[4] ? 7'h10 : 7'h20)) else $error("tx level wrong");
    a_xtal_select:
        assert property (io_settled |-> xtal_27m == io_shadow[3])
        else $error("crystal select wrong");
    a_clk_held_off:
        assert property ((io_shadow[2:1] == 2'b11) [*6] |-> $stable(mcu_clk))
        else $error("clock pin moves while disabled");
    a_lf_clock_off:
        assert property ((!xtal_running && io_shadow[0]) [*8]
            |-> $stable(mcu_clk)) else $error("low clock not suppressed");
    a_default_clears:
        assert property (set_default |-> ##[1:2] antenna_cal_target == 8'h00)
        else $error("set default left a register");
    a_addr_decode:
        assert property (addr_hit == (addr == 6'h00 || (addr >= 6'h21 &&
            addr != 6'h28 && addr != 6'h3e))) else $error("decode wrong");
    a_read_answer:
        assert property (rd_en |=> rd_valid) else $error("read not answered");
    a_valid_cause:
        assert property (rd_valid |-> $past(rd_en))
        else $error("read valid without read");
    a_unmapped_zero:
        assert property (rd_en && !addr_hit |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    c_default: cover property (set_default);
    c_unmapped: cover property (rd_en && !addr_hit);
    c_second_drv: cover property (io_shadow[7] && io_shadow[6]);
endmodule

bind reader_upper_regs reader_upper_regs_props chk_u (
    .clk(clk), .sys_rst(sys_rst), .set_default(set_default),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .addr_hit(addr_hit),
    .xtal_running(xtal_running), .driver_a_en(driver_a_en),
    .driver_b_en(driver_b_en), .differential(differential),
    .rx_water_level(rx_water_level), .tx_water_level(tx_water_level),
    .xtal_27m(xtal_27m), .mcu_clk(mcu_clk),
    .antenna_cal_target(antenna_cal_target));

//--- bench/reader_host_model.sv
// host model issuing register reads and writes to the bank
`timescale 1ns/1ns
module reader_host_model (
    input  wire       clk,
    output reg        wr_en = 1'b0,
    output reg        rd_en = 1'b0,
    output reg  [5:0] addr = 6'h15,
    output reg  [7:0] wr_data = 8'h96,
    input  wire [7:0] rd_data,
    input  wire       rd_valid
);
    // no fast rate
    // never asks for very high bit rate, so any crystal setting is safe
    task wr(input [5:0] a, input [7:0] d);
        begin
            @(posedge clk);
            #1 wr_en = 1'b1;
            addr = a;
            wr_data = d;
            @(posedge clk);
            #1 wr_en = 1'b0;
            addr = ~a;
            wr_data = ~d;
        end
    endtask
    task rd(input [5:0] a, output [7:0] d, output ok);
        begin
            @(posedge clk);
            #1 rd_en = 1'b1;
            addr = a;
            @(posedge clk);
            #1 rd_en = 1'b0;
            addr = ~a;
            ok = rd_valid;
            d = rd_data;
        end
    endtask
endmodule

//--- bench/tb_nfc_reader_upper_map_io_config.sv
// self-checking bench for the upper register bank and io configuration
`timescale 1ns/1ns
module tb_nfc_reader_upper_map_io_config;
    localparam [7:0]  ID = 8'h3c; // arbitrary identity value
    localparam [63:0] RW_MASK = 64'h0cce46d6_00000000;
    localparam [63:0] RO_MASK = 64'hb331b828_00000000;
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        set_default = 1'b0;
    reg        xtal_clk = 1'b0;
    reg        xtal_running = 1'b0;
    reg  [7:0] src [0:12];
    wire       wr_en, rd_en, rd_valid, addr_hit, mcu_clk, x27, dif, da, db;
    wire [5:0] addr;
    wire [7:0] wr_data, rd_data;
    wire [7:0] cfg [0:14];
    wire [6:0] rxl, txl;
    integer    fails = 0;
    integer    n_checks = 0;
    integer    i, k, n;
    reg  [7:0] v, e;

    always #20 clk = ~clk;
    // crystal stands still while stopped
    always #37 xtal_clk = xtal_running ? ~xtal_clk : 1'b0;

    reader_upper_regs #(.IDENTITY_CODE(ID), .LF_DIV_HALF(16'd2)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .set_default(set_default),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .addr_hit(addr_hit),
        .xtal_clk(xtal_clk), .xtal_running(xtal_running),
        .ant_cal_in(src[0]), .mod_depth_in(src[1]), .reg_timer_in(src[2]),
        .sig_strength_in(src[3]), .gain_red_in(src[4]),
        .cap_sensor_in(src[5]), .aux_in(src[6]), .amp_avg_in(src[7]),
        .amp_res_in(src[8]), .ph_avg_in(src[9]), .ph_res_in(src[10]),
        .capm_avg_in(src[11]), .capm_res_in(src[12]),
        .driver_a_en(da), .driver_b_en(db), .differential(dif),
        .rx_water_level(rxl), .tx_water_level(txl), .xtal_27m(x27),
        .mcu_clk(mcu_clk), .antenna_cal_control(cfg[0]),
        .antenna_cal_target(cfg[1]), .mod_depth_control(cfg[2]),
        .driver_modulated_level(cfg[3]), .driver_normal_level(cfg[4]),
        .field_detect_threshold(cfg[5]),
        .regulator_voltage_control(cfg[6]),
        .cap_sensor_control(cfg[7]), .wake_timer_control(cfg[8]),
        .amplitude_meas_config(cfg[9]),
        .amplitude_meas_reference(cfg[10]),
        .phase_meas_config(cfg[11]), .phase_meas_reference(cfg[12]),
        .capacitance_meas_config(cfg[13]),
        .capacitance_meas_reference(cfg[14]));

    reader_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [8*10:1] nm, input [7:0] exp, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("unexpected %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task rdchk(input [5:0] a, input [7:0] exp);
        reg [7:0] d;
        reg       ok;
        begin
            host_u.rd(a, d, ok);
            chk("rd valid", 8'h01, {7'h00, ok});
            chk("rd data", exp, d);
        end
    endtask
    task io_check(input [7:0] w);
        begin
            e = {5'h00, !w[7], !w[7] | !w[6], !w[7] | w[6]};
            chk("drive", e, {5'h00, dif, da, db});
            e = w[5] ? 8'h50 : 8'h40;
            chk("rx level", e, {1'b0, rxl});
            e = w[4] ? 8'h10 : 8'h20;
            chk("tx level", e, {1'b0, txl});
            chk("crystal", {7'h00, w[3]}, {7'h00, x27});
        end
    endtask
    // settle, then count pin changes over a fixed span
    task edges(output integer cnt);
        reg last;
        begin
            cnt = 0;
            repeat (6) @(posedge clk);
            last = mcu_clk;
            repeat (60) begin
                @(posedge clk);
                #1 if (mcu_clk !== last)
                    cnt = cnt + 1;
                last = mcu_clk;
            end
        end
    endtask
    task test_done;
        begin
            if (fails == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (i = 0; i < 13; i = i + 1)
            src[i] = 8'hc0 + i[7:0];
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        rdchk(6'h00, 8'h08);
        io_check(8'h08);
        for (i = 33; i < 64; i = i + 1)
            host_u.wr(i[5:0], {2'b10, i[5:0]});
        k = 0;
        n = 0;
        for (i = 33; i < 64; i = i + 1) begin
            e = 8'h00;
            if (RW_MASK[i]) begin
                e = {2'b10, i[5:0]};
                chk("cfg port", e, cfg[n]);
                n = n + 1;
            end else if (i == 63)
                e = ID;
            else if (RO_MASK[i]) begin
                e = src[k];
                k = k + 1;
            end
            rdchk(i[5:0], e);
        end
        host_u.wr(6'h05, 8'hff);
        rdchk(6'h05, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            v = (i == 0) ? 8'h00 : (i == 5) ? 8'hc0 : (8'h08 << i);
            host_u.wr(6'h00, v);
            repeat (3) @(posedge clk);
            #1 io_check(v);
            rdchk(6'h00, v);
        end
        host_u.wr(6'h22, 8'h3c);
        @(posedge clk);
        #1 set_default = 1'b1;
        @(posedge clk);
        #1 set_default = 1'b0;
        repeat (2) @(posedge clk);
        #1 for (i = 0; i < 15; i = i + 1)
            chk("cfg clear", 8'h00, cfg[i]);
        rdchk(6'h22, 8'h00);
        rdchk(6'h00, 8'hc0);
        io_check(8'hc0);
        xtal_running = 1'b1;
        k = 0;
        for (i = 0; i < 7; i = i + 1) begin
            if (i == 4)
                xtal_running = 1'b0;
            v = (i < 4) ? {5'h00, i[1:0], 1'b0} : (i == 4) ? 8'h00 :
                (i == 5) ? 8'h01 : 8'h06;
            host_u.wr(6'h00, v);
            edges(n);
            e = {7'h00, i < 3 || i == 4};
            chk("mcu clock", e, {7'h00, n > 2});
            if (i == 1 || i == 2)
                chk("clk rate", 8'h01, {7'h00, n > k});
            k = n;
        end
        test_done;
    end
    initial begin
        #400000;
        fails = fails + 1;
        test_done;
    end
endmodule
